/* verilog/laser_shutdown_soak_ctrl.sv */
// Purpose: Per-port laser safety shutdown and auto in service soak control
// Assumes: All inputs synchronous to sys_clk; commands are one-cycle pulses
// Notes: Commands are sampled on the rising edge; every output is a flop
`timescale 1ns/1ps
module laser_shutdown_soak_ctrl #(
    parameter longint STEP_CYCLES = laser_shutdown_soak_pkg::STEP_CYCLES_DOC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic modeWrite,
    input wire laser_shutdown_soak_pkg::shutdownMode_t modeIn,
    input wire logic isGigEthernet,
    input wire logic isInterlink,
    input wire logic inputSignalLoss,
    input wire logic operatorRestart,
    input wire logic testRestart,
    input wire logic soakWrite,
    input wire logic [laser_shutdown_soak_pkg::SOAK_STEP_W-1:0] soakSteps,
    input wire logic adminInService,
    input wire logic adminAutoInService,
    output logic laserEnable,
    output laser_shutdown_soak_pkg::shutdownMode_t laserSafetyShutdown,
    output logic shutdownLatched,
    output logic modeRejected,
    output logic inServiceState,
    output logic autoInService,
    output logic soakRejected
);
    import laser_shutdown_soak_pkg::*;

    // ******************************************************************
    // Timing: each command acts on the edge that samples it, and its
    // answer shows on the outputs just after that same edge
    // ******************************************************************

    // ******************************************************************
    // State of the block
    // ******************************************************************
    typedef struct packed {
        shutdownMode_t mode;            // Active shutdown mode
        logic latched;                  // Laser held off by a loss
        logic laserOn;                  // Transmit laser enable
        logic modeRej;                  // Pulse: mode write refused
        logic [SOAK_STEP_W-1:0] soak;   // Programmed soak in steps
        logic soakRej;                  // Pulse: soak write refused
        svcState_t svc;                 // Port service state
        logic inSvc;                    // Port is in service
        logic autoSvc;                  // Port is soaking in auto in service
    } ctrlState_t;

    ctrlState_t s_q, s_d;
    logic [SOAK_STEP_W-1:0] stepsDone;  // Whole steps of valid input
    logic soakRun;                      // Soak timer may count

    // Soaking only counts while the input is valid
    // Loss is taken as already clean; any debounce belongs upstream
    // Loss restarts soak
    assign soakRun = (s_q.svc == SVC_SOAK) && !inputSignalLoss;

    // ******************************************************************
    // Soak timer
    // ******************************************************************
    // Step length is shortened only for simulation runs
    soak_step_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(soakRun),
        .steps(stepsDone)
    );

    // Mode check shared by write path and port reconfiguration
    // The spare code 3 is never a legal mode and is always refused
    function automatic logic modeAllowed(input shutdownMode_t m, input logic gig);
        modeAllowed = 1'b1;
        case (m)
            MODE_DISABLED, MODE_MANUAL_RESTART: modeAllowed = 1'b1;
            MODE_AUTO_RESTART: modeAllowed = !gig;
            default: modeAllowed = 1'b0;
        endcase
    endfunction

    // ******************************************************************
    // Next state
    // ******************************************************************
    always_comb begin
        s_d = s_q;
        s_d.modeRej = 1'b0;
        s_d.soakRej = 1'b0;

        // Mode write; illegal or refused modes keep the old mode
        if (modeWrite) begin
            if (modeAllowed(modeIn, isGigEthernet)) begin
                s_d.mode = modeIn;
            end else begin
                s_d.modeRej = 1'b1;
            end
        end else if (!modeAllowed(s_q.mode, isGigEthernet)) begin
            // Port turned Gigabit Ethernet under auto restart: fall back safe
            // Manual restart keeps the laser off after a loss, the cautious
            // choice while software has not yet picked a new mode
            s_d.mode = MODE_MANUAL_RESTART;
        end

        // Soak write; beyond 48 hours is refused
        // A refused write keeps the previous period in force
        if (soakWrite) begin
            if (soakSteps <= SOAK_STEP_W'(SOAK_STEPS_MAX)) begin
                s_d.soak = soakSteps;
            end else begin
                s_d.soakRej = 1'b1;
            end
        end

        // Laser gating by mode
        // Gating uses the next mode, so a mode write acts at once
        case (s_d.mode)
            MODE_DISABLED: begin
                s_d.latched = 1'b0;
            end
            MODE_AUTO_RESTART: begin
                s_d.latched = inputSignalLoss;
            end
            MODE_MANUAL_RESTART: begin
                if (inputSignalLoss) begin
                    s_d.latched = 1'b1;
                end else if (operatorRestart) begin
                    s_d.latched = 1'b0;
                end
            end
            default: begin
                // Unreachable: mode is always legal once written
                s_d.latched = 1'b0;
            end
        endcase
        // Test restart only overrides while held; the latch is left alone,
        // so the laser drops again once the test ends and loss persists
        // Test forces laser on
        s_d.laserOn = !s_d.latched || testRestart;

        // Service state machine
        case (s_q.svc)
            SVC_OUT: begin
                if (adminAutoInService && !isInterlink) begin
                    s_d.svc = SVC_SOAK;
                end else if (adminInService) begin
                    s_d.svc = SVC_IN;
                end
            end
            SVC_SOAK: begin
                // A soak of zero steps finishes on the first clean cycle
                if (isInterlink || !adminAutoInService) begin
                    // Leaving soak by admin or port role change
                    s_d.svc = adminInService ? SVC_IN : SVC_OUT;
                end else if (!inputSignalLoss && stepsDone >= s_q.soak) begin
                    s_d.svc = SVC_IN;
                end
            end
            SVC_IN: begin
                // Taking the port out by admin wins over everything
                if (!adminInService) begin
                    s_d.svc = SVC_OUT;
                end
            end
            default: begin
                // Unreachable code: park the port out of service
                s_d.svc = SVC_OUT;
            end
        endcase

        // Service outputs kept as their own flops so the ports are not
        // decoded from the state vector after the register
        s_d.inSvc = (s_d.svc == SVC_IN);
        s_d.autoSvc = (s_d.svc == SVC_SOAK);
    end

    // ******************************************************************
    // State register
    // ******************************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // Laser stays lit in reset, as disabled mode asks
            // Reset to disabled
            s_q.mode <= MODE_RESET;
            s_q.latched <= 1'b0;
            s_q.laserOn <= 1'b1;
            s_q.modeRej <= 1'b0;
            s_q.soak <= '0;
            s_q.soakRej <= 1'b0;
            s_q.svc <= SVC_OUT;
            s_q.inSvc <= 1'b0;
            s_q.autoSvc <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state flops
    assign laserEnable = s_q.laserOn;
    assign laserSafetyShutdown = s_q.mode;
    assign shutdownLatched = s_q.latched;
    assign modeRejected = s_q.modeRej;
    assign soakRejected = s_q.soakRej;
    assign inServiceState = s_q.inSvc;
    assign autoInService = s_q.autoSvc;
endmodule

/* verilog/laser_shutdown_soak_pkg.sv */
// Purpose: Shared constants and types for the laser shutdown and soak control block
// Assumes: 25 MHz system clock
// Notes: Soak period is programmed in quarter-hour steps
package laser_shutdown_soak_pkg;

    // ******************************************************************
    // Laser safety shutdown modes
    // ******************************************************************
    typedef enum logic [1:0] {
        MODE_DISABLED = 2'h0,      // No shutdown on signal loss
        MODE_AUTO_RESTART = 2'h1,  // Off on loss, back on when loss clears
        MODE_MANUAL_RESTART = 2'h2 // Off on loss, back on by operator only
    } shutdownMode_t;

    // Mode after reset
    localparam shutdownMode_t MODE_RESET = MODE_DISABLED;

    // ******************************************************************
    // Soak timing
    // ******************************************************************
    // Soak step in minutes, and the largest step count (48 hours)
    localparam int SOAK_STEP_MIN = 15;
    localparam int SOAK_MAX_HOURS = 48;
    localparam int SOAK_STEPS_MAX = SOAK_MAX_HOURS * 60 / SOAK_STEP_MIN;
    localparam int SOAK_STEP_W = 8;
    // System clock rate in Hz
    localparam longint CLK_HZ = 25000000;
    // Cycles in one soak step, derived from step time and clock rate
    localparam longint STEP_CYCLES_DOC = longint'(SOAK_STEP_MIN) * 60 * CLK_HZ;
    localparam int TICK_W = 36;

    // ******************************************************************
    // Port service states
    // ******************************************************************
    typedef enum logic [2:0] {
        SVC_OUT = 3'h1,    // Out of service
        SVC_SOAK = 3'h2,   // Auto in service, soaking
        SVC_IN = 3'h4      // In service
    } svcState_t;

endpackage

/* verilog/soak_step_timer.sv */
// Purpose: Counts whole soak steps while a valid input persists
// Assumes: Cleared whenever the input is not valid or soak is not active
// Notes: Step length is a parameter so a simulation can shorten it
`timescale 1ns/1ps
module soak_step_timer #(
    parameter longint STEP_CYCLES = laser_shutdown_soak_pkg::STEP_CYCLES_DOC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic run,
    output logic [laser_shutdown_soak_pkg::SOAK_STEP_W-1:0] steps
);
    import laser_shutdown_soak_pkg::*;

    // ******************************************************************
    // State
    // ******************************************************************
    typedef struct packed {
        logic [TICK_W-1:0] tick;      // Cycles inside current step
        logic [SOAK_STEP_W-1:0] step; // Whole steps elapsed
    } timerState_t;

    timerState_t s_q, s_d;

    // Next state: restart from zero when run drops
    always_comb begin
        s_d = s_q;
        if (!run) begin
            s_d.tick = '0;
            s_d.step = '0;
        end else if (s_q.tick == TICK_W'(STEP_CYCLES - 1)) begin
            s_d.tick = '0;
            // Saturate so a long soak never wraps
            if (s_q.step != {SOAK_STEP_W{1'b1}}) begin
                s_d.step = s_q.step + 1'b1;
            end
        end else begin
            s_d.tick = s_q.tick + 1'b1;
        end
    end

    // Register the state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign steps = s_q.step;
endmodule

/* testbench/laser_shutdown_soak_properties.sv */
// Purpose: Port checker for the laser shutdown and soak block
// Assumes: One clock, asynchronous active-low reset
// Notes: Attached by bind at the foot of this file
`timescale 1ns/1ps
module laser_shutdown_soak_properties
    import laser_shutdown_soak_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic modeWrite,
    input wire shutdownMode_t modeIn,
    input wire logic isGigEthernet,
    input wire logic isInterlink,
    input wire logic inputSignalLoss,
    input wire logic operatorRestart,
    input wire logic testRestart,
    input wire logic soakWrite,
    input wire logic [SOAK_STEP_W-1:0] soakSteps,
    input wire logic adminAutoInService,
    input wire logic laserEnable,
    input wire shutdownMode_t laserSafetyShutdown,
    input wire logic shutdownLatched,
    input wire logic modeRejected,
    input wire logic inServiceState,
    input wire logic autoInService,
    input wire logic soakRejected
);
    // One domain, so clock and reset are given once
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    rstMode_a: assert property ($rose(rstn) |-> laserSafetyShutdown == MODE_DISABLED)
        else $error("mode not disabled after reset");
    disOn_a: assert property (laserSafetyShutdown == MODE_DISABLED && !modeWrite |=> laserEnable)
        else $error("laser off in disabled mode");
    autoOff_a: assert property (laserSafetyShutdown == MODE_AUTO_RESTART
        && inputSignalLoss && !testRestart && !modeWrite |=> !laserEnable)
        else $error("laser on during loss in auto mode");
    autoOn_a: assert property (laserSafetyShutdown == MODE_AUTO_RESTART
        && !inputSignalLoss && !modeWrite && !isGigEthernet |=> laserEnable)
        else $error("laser not restarted in auto mode");
    gbeRej_a: assert property (modeWrite && modeIn == MODE_AUTO_RESTART
        && isGigEthernet |=> modeRejected && laserSafetyShutdown != MODE_AUTO_RESTART)
        else $error("auto restart taken on gigabit port");
    gbeFall_a: assert property (laserSafetyShutdown == MODE_AUTO_RESTART
        && isGigEthernet && !modeWrite |=> laserSafetyShutdown == MODE_MANUAL_RESTART)
        else $error("auto restart kept on gigabit port");
    manHold_a: assert property (laserSafetyShutdown == MODE_MANUAL_RESTART
        && shutdownLatched && !operatorRestart && !testRestart && !modeWrite |=> !laserEnable)
        else $error("laser on while latched off");
    testOn_a: assert property (testRestart |=> laserEnable)
        else $error("test restart did not light laser");
    soakRej_a: assert property (soakWrite && soakSteps > 8'hc0 |=> soakRejected)
        else $error("soak above limit accepted");
    noAins_a: assert property (isInterlink |=> !autoInService)
        else $error("soak state on interlink port");
    soakClr_a: assert property (autoInService && inputSignalLoss
        && adminAutoInService && !isInterlink |=> !inServiceState)
        else $error("in service despite loss");
endmodule
bind laser_shutdown_soak_ctrl laser_shutdown_soak_properties chk_u (.*);

/* testbench/far_end_xcvr.sv */
// Purpose: Far-end transceiver model feeding the loss indication
// Assumes: Light arrives one cycle after the far transmitter acts
// Notes: Loss is a clean level, never unknown
`timescale 1ns/1ps
module far_end_xcvr (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic txOff,
    output logic lossOut
);
    // Loss follows the far transmitter state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lossOut <= 1'h0;
        end else begin
            lossOut <= txOff;
        end
    end
endmodule

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the laser shutdown and soak block
// Assumes: Soak step shortened to 4 cycles
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb_top;
    import laser_shutdown_soak_pkg::*;
    logic sys_clk = 1'h0, rstn = 1'h0, modeWrite = 1'h0, isGigEthernet = 1'h0;
    logic isInterlink = 1'h0, operatorRestart = 1'h0, testRestart = 1'h0, soakWrite = 1'h0;
    logic adminInService = 1'h0, adminAutoInService = 1'h0, txOff = 1'h0, inputSignalLoss;
    logic laserEnable, shutdownLatched, modeRejected, inServiceState, autoInService;
    logic soakRejected;
    logic [7:0] soakSteps = 8'h00;
    shutdownMode_t modeIn = MODE_DISABLED, laserSafetyShutdown;
    int error_cnt = 0, compares = 0, n;
    laser_shutdown_soak_ctrl #(.STEP_CYCLES(4)) dut_u (.sys_clk(sys_clk), .rstn(rstn),
        .modeWrite(modeWrite), .modeIn(modeIn), .isGigEthernet(isGigEthernet),
        .isInterlink(isInterlink), .inputSignalLoss(inputSignalLoss),
        .operatorRestart(operatorRestart), .testRestart(testRestart), .soakWrite(soakWrite),
        .soakSteps(soakSteps), .adminInService(adminInService),
        .adminAutoInService(adminAutoInService), .laserEnable(laserEnable),
        .laserSafetyShutdown(laserSafetyShutdown), .shutdownLatched(shutdownLatched),
        .modeRejected(modeRejected), .inServiceState(inServiceState),
        .autoInService(autoInService), .soakRejected(soakRejected));
    far_end_xcvr far_u (.sys_clk(sys_clk), .rstn(rstn), .txOff(txOff),
        .lossOut(inputSignalLoss));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic step(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("Counts: compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One-cycle command pulses, answer visible right after
    task automatic setMode(input shutdownMode_t m);
        modeIn = m;
        modeWrite = 1'h1;
        step(1);
        modeWrite = 1'h0;
    endtask
    task automatic setSoak(input logic [7:0] v, input logic rej);
        soakSteps = v;
        soakWrite = 1'h1;
        step(1);
        soakWrite = 1'h0;
        chk("soakRejected", {7'h00, rej}, soakRejected);
        step(1);
    endtask
    initial begin
        step(3);
        rstn = 1'h1;
        chk("mode", MODE_DISABLED, laserSafetyShutdown);
        txOff = 1'h1;
        step(3);
        chk("laser", 8'h01, laserEnable);
        setMode(MODE_AUTO_RESTART);
        step(1);
        chk("laser", 8'h00, laserEnable);
        txOff = 1'h0;
        step(3);
        chk("laser", 8'h01, laserEnable);
        setMode(MODE_MANUAL_RESTART);
        txOff = 1'h1;
        step(3);
        chk("latched", 8'h01, shutdownLatched);
        txOff = 1'h0;
        step(3);
        chk("laser", 8'h00, laserEnable);
        operatorRestart = 1'h1;
        step(1);
        operatorRestart = 1'h0;
        chk("laser", 8'h01, laserEnable);
        txOff = 1'h1;
        step(3);
        testRestart = 1'h1;
        step(1);
        chk("laser", 8'h01, laserEnable);
        testRestart = 1'h0;
        txOff = 1'h0;
        $display("Test laser modes done");
        isGigEthernet = 1'h1;
        setMode(MODE_AUTO_RESTART);
        chk("modeRejected", 8'h01, modeRejected);
        chk("mode", MODE_MANUAL_RESTART, laserSafetyShutdown);
        step(1);
        setMode(shutdownMode_t'(2'h3));
        chk("modeRejected", 8'h01, modeRejected);
        step(1);
        setMode(MODE_DISABLED);
        chk("mode", MODE_DISABLED, laserSafetyShutdown);
        isGigEthernet = 1'h0;
        step(1);
        setMode(MODE_AUTO_RESTART);
        chk("mode", MODE_AUTO_RESTART, laserSafetyShutdown);
        isGigEthernet = 1'h1;
        step(2);
        chk("mode", MODE_MANUAL_RESTART, laserSafetyShutdown);
        isGigEthernet = 1'h0;
        step(1);
        setMode(MODE_DISABLED);
        chk("mode", MODE_DISABLED, laserSafetyShutdown);
        $display("Test mode refusal done");
        setSoak(8'hc1, 1'h1);
        setSoak(8'hc0, 1'h0);
        setSoak(8'h02, 1'h0);
        txOff = 1'h1;
        step(2);
        adminAutoInService = 1'h1;
        step(2);
        chk("autoInService", 8'h01, autoInService);
        txOff = 1'h0;
        step(5);
        txOff = 1'h1;
        step(2);
        chk("inService", 8'h00, inServiceState);
        txOff = 1'h0;
        n = 0;
        while (inServiceState !== 1'h1 && n < 40) begin
            step(1);
            n++;
        end
        chk("soakTime", 8'h01, {7'h00, n >= 9 && n <= 13});
        // A soak that never completes has been counted; go to the report
        if (n < 40) begin
            adminInService = 1'h1;
            adminAutoInService = 1'h0;
            step(2);
            chk("inService", 8'h01, inServiceState);
            adminInService = 1'h0;
            isInterlink = 1'h1;
            adminAutoInService = 1'h1;
            step(3);
            chk("autoInService", 8'h00, autoInService);
        end
        $display("Test soak done");
        print_verdict();
    end
endmodule
